// ===== hw/csi_params.svh
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH
// data memory locations of the core registers
`define CSI_A_FIRST_INDIRECT_WINDOW     8'h00
`define CSI_A_MP0      8'h01
`define CSI_A_SECOND_INDIRECT_WINDOW     8'h02
`define CSI_A_MP1      8'h03
`define CSI_A_BP       8'h04
`define CSI_A_ACC      8'h05
`define CSI_A_PCL      8'h06
`define CSI_A_STATUS   8'h0a
`define CSI_A_PAC      8'h11
`define CSI_A_SYSTEM_CONTROL_FIRST    8'h1a
// general purpose area: 0x40..0x7f in each bank
`define CSI_GPR_TAG    2'b01
`define CSI_GPR_DEPTH  64
// bus word indexes beyond the data memory window
`define CSI_IDX_CMD    9'h100
`define CSI_IDX_STATE  9'h101
// status bit positions
`define CSI_ST_C       0
`define CSI_ST_AC      1
`define CSI_ST_Z       2
`define CSI_ST_OV      3
`define CSI_ST_PDF     4
`define CSI_ST_TO      5
// control register bit positions
`define CSI_CT_CLKSEL  0
`define CSI_CT_XTALLP  1
`define CSI_CT_DIVPIN  2
`define CSI_CT_DIVSRC  6
// command word: operand in [7:0], operation in [11:8]
`define CSI_OP_ADD     4'h0
`define CSI_OP_SUB     4'h1
`define CSI_OP_AND     4'h2
`define CSI_OP_OR      4'h3
`define CSI_OP_XOR     4'h4
`define CSI_OP_RLC     4'h5
`define CSI_OP_RRC     4'h6
`define CSI_OP_MOVK    4'h7
`define CSI_OP_LOAD    4'h8
`define CSI_OP_STORE   4'h9
`define CSI_OP_CLRWDT  4'ha
`define CSI_OP_HALT    4'hb
`define CSI_OP_SOFTRST 4'hc
// reset values
`define CSI_RST_BYTE   8'h00
`define CSI_RST_WORD   32'h0000_0000
`endif

// ===== hw/csi_pkg.sv
`default_nettype none
package csi_pkg;
  typedef enum logic {CSI_PH_IDLE, CSI_PH_WAIT} csi_phase_t;
  typedef logic [7:0] csi_byte_t;
  // {null access, bank, effective address}
  typedef logic [9:0] csi_target_t;
endpackage
`default_nettype wire

// ===== hw/csi_core_sfr.sv
`include "csi_params.svh"
`default_nettype none
module csi_core_sfr
  import csi_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        WDT_TIMEOUT_I,
  input  wire logic        CLK_CFG_SLOW_I,
  output logic             PC_JUMP_O,
  output logic      [7:0]  PC_LOW_O,
  output logic             PC_DUMMY_O,
  output logic      [7:0]  PORT_OUT_EN_O,
  output logic             DIV_SRC_O,
  output logic             DIV_PIN_EN_O,
  output logic             SLOW_XTAL_LP_O,
  output logic             SYS_CLK_SLOW_O,
  output logic             HALTED_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  csi_phase_t  phase;
  logic [8:0]  a_idx;
  logic        a_write;
  csi_byte_t   mp0;
  csi_byte_t   mp1;
  logic        bp;
  csi_byte_t   acc;
  csi_byte_t   program_counter_low;
  csi_byte_t   port_direction_register;
  logic        fc;
  logic        fac;
  logic        fz;
  logic        fov;
  logic        fto;
  logic        fpdf;
  logic        div_src;
  logic        div_pin;
  logic        xtal_lp;
  logic        clk_sel;
  logic        halted;
  logic        cfg_meta;
  logic        cfg_sync;
  csi_byte_t   ram [2][`CSI_GPR_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // address resolution

  function automatic csi_target_t resolve(input csi_byte_t a, input csi_byte_t p0,
                                          input csi_byte_t p1, input logic b);
    csi_byte_t t;
    logic      tb;
    logic      nul;
    t   = a;
    tb  = 1'b0;
    nul = 1'b0;
    if (a == `CSI_A_FIRST_INDIRECT_WINDOW) begin
      t = p0;
    end else if (a == `CSI_A_SECOND_INDIRECT_WINDOW) begin
      t  = p1;
      tb = b;
    end
    if ((a == `CSI_A_FIRST_INDIRECT_WINDOW) || (a == `CSI_A_SECOND_INDIRECT_WINDOW)) begin
      nul = (t == `CSI_A_FIRST_INDIRECT_WINDOW) || (t == `CSI_A_SECOND_INDIRECT_WINDOW);
    end
    return {nul, tb, t};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        accept;
  logic        dphase;
  logic        bus_wr;
  logic        cmd_go;
  logic [3:0]  op;
  csi_byte_t   k;
  csi_byte_t   rd_addr;
  csi_byte_t   wr_addr;
  csi_byte_t   wr_data;
  logic        wr_go;
  csi_target_t rd_t;
  csi_target_t wr_t;
  logic        w_ok;
  csi_byte_t   w_a;
  csi_byte_t   rd_val;
  logic [31:0] bus_rd;

  assign accept  = HSEL_I && HTRANS_I[1] && HREADY_I && (phase == CSI_PH_IDLE);
  assign dphase  = (phase == CSI_PH_WAIT);
  assign bus_wr  = dphase && a_write && !a_idx[8];
  assign cmd_go  = dphase && a_write && (a_idx == `CSI_IDX_CMD);
  assign op      = HWDATA_I[11:8];
  assign k       = HWDATA_I[7:0];
  assign rd_addr = cmd_go ? k : a_idx[7:0];
  // command stores write the accumulator; bus writes take their own data
  assign wr_go   = bus_wr || (cmd_go && (op == `CSI_OP_STORE));
  assign wr_addr = bus_wr ? a_idx[7:0] : k;
  assign wr_data = bus_wr ? HWDATA_I[7:0] : acc;
  assign rd_t    = resolve(rd_addr, mp0, mp1, bp);
  assign wr_t    = resolve(wr_addr, mp0, mp1, bp);
  assign w_ok    = wr_go && !wr_t[9];
  assign w_a     = wr_t[7:0];

  // special registers decode without the bank bit
  always_comb begin
    rd_val = `CSI_RST_BYTE;
    if (!rd_t[9]) begin
      unique case (rd_t[7:0])
        `CSI_A_MP0:    rd_val = mp0;
        `CSI_A_MP1:    rd_val = mp1;
        `CSI_A_BP:     rd_val = {7'h00, bp};
        `CSI_A_ACC:    rd_val = acc;
        `CSI_A_PCL:    rd_val = program_counter_low;
        `CSI_A_STATUS: rd_val = {2'b00, fto, fpdf, fov, fz, fac, fc};
        `CSI_A_PAC:    rd_val = port_direction_register;
        `CSI_A_SYSTEM_CONTROL_FIRST:  rd_val = {1'b0, div_src, 3'b000, div_pin, xtal_lp, clk_sel};
        default: begin
          if (rd_t[7:6] == `CSI_GPR_TAG) begin
            rd_val = ram[rd_t[8]][rd_t[5:0]];
          end
        end
      endcase
    end
  end

  always_comb begin
    bus_rd = `CSI_RST_WORD;
    if (!a_idx[8]) begin
      bus_rd = {24'h000000, rd_val};
    end else if (a_idx == `CSI_IDX_STATE) begin
      bus_rd = {29'h00000000, cfg_sync, bp, halted};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: one wait state per transfer

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      phase       <= CSI_PH_IDLE;
      a_idx       <= 9'h000;
      a_write     <= 1'b0;
      HREADYOUT_O <= 1'b1;
    end else if (accept) begin
      phase       <= CSI_PH_WAIT;
      a_idx       <= HADDR_I[10:2];
      a_write     <= HWRITE_I;
      HREADYOUT_O <= 1'b0;
    end else begin
      phase       <= CSI_PH_IDLE;
      HREADYOUT_O <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HRDATA_O <= `CSI_RST_WORD;
    end else if (dphase && !a_write) begin
      HRDATA_O <= bus_rd;
    end
  end

  // only single word transfers, so every answer is okay
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HRESP_O <= 1'b0;
    end else begin
      HRESP_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alu

  logic       is_sub;
  csi_byte_t  opb;
  logic [8:0] sum;
  logic [4:0] lo;
  logic       alu_arith;
  logic       alu_logic;
  csi_byte_t  logic_res;

  assign is_sub    = (op == `CSI_OP_SUB);
  assign opb       = is_sub ? ~k : k;
  assign sum       = {1'b0, acc} + {1'b0, opb} + {8'h00, is_sub};
  assign lo        = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub};
  assign alu_arith = cmd_go && ((op == `CSI_OP_ADD) || is_sub);
  assign alu_logic = cmd_go && ((op == `CSI_OP_AND) || (op == `CSI_OP_OR)
                                || (op == `CSI_OP_XOR));

  always_comb begin
    logic_res = acc ^ k;
    if (op == `CSI_OP_AND) begin
      logic_res = acc & k;
    end else if (op == `CSI_OP_OR) begin
      logic_res = acc | k;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc <= `CSI_RST_BYTE;
    end else if (w_ok && (w_a == `CSI_A_ACC)) begin
      acc <= wr_data;
    end else if (alu_arith) begin
      acc <= sum[7:0];
    end else if (alu_logic) begin
      acc <= logic_res;
    end else if (cmd_go && (op == `CSI_OP_RLC)) begin
      acc <= {acc[6:0], fc};
    end else if (cmd_go && (op == `CSI_OP_RRC)) begin
      acc <= {fc, acc[7:1]};
    end else if (cmd_go && (op == `CSI_OP_MOVK)) begin
      acc <= k;
    end else if (cmd_go && (op == `CSI_OP_LOAD)) begin
      acc <= rd_val;
    end
  end

  // subtract is add of inverse plus one: carry out means no borrow
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fc  <= 1'b0;
      fac <= 1'b0;
      fz  <= 1'b0;
      fov <= 1'b0;
    end else if (w_ok && (w_a == `CSI_A_STATUS)) begin
      fc  <= wr_data[`CSI_ST_C];
      fac <= wr_data[`CSI_ST_AC];
      fz  <= wr_data[`CSI_ST_Z];
      fov <= wr_data[`CSI_ST_OV];
    end else if (alu_arith) begin
      fc  <= sum[8];
      fac <= lo[4];
      fz  <= (sum[7:0] == 8'h00);
      fov <= sum[8] ^ (sum[7] ^ acc[7] ^ opb[7]);
    end else if (alu_logic) begin
      fz  <= (logic_res == 8'h00);
    end else if (cmd_go && (op == `CSI_OP_RLC)) begin
      fc  <= acc[7];
    end else if (cmd_go && (op == `CSI_OP_RRC)) begin
      fc  <= acc[0];
    end
  end
  // no shadow copy exists; handlers must save status themselves

  ////////////////////////////////////////////////////////////////////////////
  // system flags, halt and bank

  logic wdt_to;
  logic watchdog_clear_instruction;
  logic do_halt;
  logic soft_rst;

  assign wdt_to   = WDT_TIMEOUT_I;
  assign watchdog_clear_instruction  = cmd_go && (op == `CSI_OP_CLRWDT);
  assign do_halt  = cmd_go && (op == `CSI_OP_HALT);
  assign soft_rst = cmd_go && (op == `CSI_OP_SOFTRST);

  // status writes never reach these two
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fto <= 1'b0;
    end else if (wdt_to) begin
      fto <= 1'b1;
    end else if (watchdog_clear_instruction || do_halt) begin
      fto <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fpdf <= 1'b0;
    end else if (do_halt) begin
      fpdf <= 1'b1;
    end else if (watchdog_clear_instruction) begin
      fpdf <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      halted <= 1'b0;
    end else if (wdt_to || soft_rst) begin
      halted <= 1'b0;
    end else if (do_halt) begin
      halted <= 1'b1;
    end
  end

  // a timeout while halted is a wake-up, so the bank survives
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bp <= 1'b0;
    end else if (soft_rst || (wdt_to && !halted)) begin
      bp <= 1'b0;
    end else if (w_ok && (w_a == `CSI_A_BP)) begin
      bp <= wr_data[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointers, port direction, control

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mp0 <= `CSI_RST_BYTE;
      mp1 <= `CSI_RST_BYTE;
    end else begin
      if (w_ok && (w_a == `CSI_A_MP0)) begin
        mp0 <= wr_data;
      end
      if (w_ok && (w_a == `CSI_A_MP1)) begin
        mp1 <= wr_data;
      end
    end
  end

  // reset to all inputs: nothing is driven before software decides
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      port_direction_register           <= 8'hff;
      PORT_OUT_EN_O <= 8'h00;
    end else begin
      if (w_ok && (w_a == `CSI_A_PAC)) begin
        port_direction_register <= wr_data;
      end
      PORT_OUT_EN_O <= ~port_direction_register;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      div_src <= 1'b0;
      div_pin <= 1'b0;
      xtal_lp <= 1'b0;
      clk_sel <= 1'b0;
    end else if (w_ok && (w_a == `CSI_A_SYSTEM_CONTROL_FIRST)) begin
      div_src <= wr_data[`CSI_CT_DIVSRC];
      div_pin <= wr_data[`CSI_CT_DIVPIN];
      xtal_lp <= wr_data[`CSI_CT_XTALLP];
      clk_sel <= wr_data[`CSI_CT_CLKSEL];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_meta <= 1'b0;
      cfg_sync <= 1'b0;
    end else begin
      cfg_meta <= CLK_CFG_SLOW_I;
      cfg_sync <= cfg_meta;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DIV_SRC_O      <= 1'b0;
      DIV_PIN_EN_O   <= 1'b0;
      SLOW_XTAL_LP_O <= 1'b0;
      SYS_CLK_SLOW_O <= 1'b0;
      HALTED_O       <= 1'b0;
    end else begin
      DIV_SRC_O      <= div_src;
      DIV_PIN_EN_O   <= div_pin;
      SLOW_XTAL_LP_O <= xtal_lp;
      SYS_CLK_SLOW_O <= clk_sel && cfg_sync;
      HALTED_O       <= halted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter low

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      program_counter_low        <= `CSI_RST_BYTE;
      PC_LOW_O   <= `CSI_RST_BYTE;
      PC_JUMP_O  <= 1'b0;
      PC_DUMMY_O <= 1'b0;
    end else begin
      PC_JUMP_O  <= 1'b0;
      PC_DUMMY_O <= PC_JUMP_O;
      if (w_ok && (w_a == `CSI_A_PCL)) begin
        program_counter_low       <= wr_data;
        PC_LOW_O  <= wr_data;
        PC_JUMP_O <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general purpose ram, two banks

  always_ff @(posedge SYS_CLK_I) begin
    if (w_ok && (w_a[7:6] == `CSI_GPR_TAG)) begin
      ram[wr_t[8]][w_a[5:0]] <= wr_data;
    end
  end

endmodule
`default_nettype wire

// ===== test/csi_core_sfr_sva.sv
`include "csi_params.svh"
`default_nettype none
module csi_core_sfr_sva (
  input wire logic        SYS_CLK_I,
  input wire logic        RST_B_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic        HREADY_I,
  input wire logic        HREADYOUT_O,
  input wire logic        WDT_TIMEOUT_I,
  input wire logic        CLK_CFG_SLOW_I,
  input wire logic        PC_JUMP_O,
  input wire logic [7:0]  PC_LOW_O,
  input wire logic        PC_DUMMY_O,
  input wire logic [7:0]  PORT_OUT_EN_O,
  input wire logic        DIV_SRC_O,
  input wire logic        DIV_PIN_EN_O,
  input wire logic        SLOW_XTAL_LP_O,
  input wire logic        SYS_CLK_SLOW_O,
  input wire logic        HALTED_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  //////////////////////////////
  // write address phase accepted at one data-memory index
  sequence s_wr_take(logic [7:0] idx);
    HSEL_I && HTRANS_I[1] && HREADY_I && HREADYOUT_O && HWRITE_I
      && HADDR_I[31:10] == 22'h0 && HADDR_I[9:2] == idx;
  endsequence
  sequence s_jump_dummy;
    PC_JUMP_O ##1 (PC_DUMMY_O && !PC_JUMP_O);
  endsequence
  AST_PCL_JUMP:
    assert property (s_wr_take(`CSI_A_PCL) |=> ##1 (PC_JUMP_O
      && PC_LOW_O == $past(HWDATA_I[7:0])))
    else $error("no jump after counter low write");
  AST_JUMP_DUMMY:
    assert property (PC_JUMP_O |-> s_jump_dummy)
    else $error("jump not followed by one dummy cycle");
  AST_DUMMY_CAUSE:
    assert property (PC_DUMMY_O |-> $past(PC_JUMP_O))
    else $error("dummy cycle without jump");
  AST_READY_ONE:
    assert property (!HREADYOUT_O |=> HREADYOUT_O)
    else $error("wait state longer than one cycle");
  AST_DIR_EN:
    assert property (s_wr_take(`CSI_A_PAC) |=> ##2
      PORT_OUT_EN_O == ~$past(HWDATA_I[7:0], 2))
    else $error("output enables not inverse of direction");
  AST_CTL_OUT:
    assert property (s_wr_take(`CSI_A_SYSTEM_CONTROL_FIRST) |=> ##2 (DIV_SRC_O == $past(HWDATA_I[6], 2)
      && DIV_PIN_EN_O == $past(HWDATA_I[2], 2) && SLOW_XTAL_LP_O == $past(HWDATA_I[1], 2)))
    else $error("control outputs differ from written bits");
  AST_SLOW_CFG:
    assert property (!CLK_CFG_SLOW_I [*4] |=> !SYS_CLK_SLOW_O)
    else $error("slow clock chosen without configuration");
  AST_WAKE:
    assert property (WDT_TIMEOUT_I && HALTED_O |=> ##1 !HALTED_O)
    else $error("time-out did not wake from halt");
endmodule
bind csi_core_sfr csi_core_sfr_sva chk_u (
  .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
  .HREADYOUT_O(HREADYOUT_O), .WDT_TIMEOUT_I(WDT_TIMEOUT_I),
  .CLK_CFG_SLOW_I(CLK_CFG_SLOW_I), .PC_JUMP_O(PC_JUMP_O), .PC_LOW_O(PC_LOW_O),
  .PC_DUMMY_O(PC_DUMMY_O), .PORT_OUT_EN_O(PORT_OUT_EN_O), .DIV_SRC_O(DIV_SRC_O),
  .DIV_PIN_EN_O(DIV_PIN_EN_O), .SLOW_XTAL_LP_O(SLOW_XTAL_LP_O),
  .SYS_CLK_SLOW_O(SYS_CLK_SLOW_O), .HALTED_O(HALTED_O)
);
`default_nettype wire

// ===== test/tb_core_sfr_indirect_status.sv
`include "csi_params.svh"
`default_nettype none
module tb_core_sfr_indirect_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        wdt     = 1'b0;
  logic        cfg     = 1'b0;
  logic [31:0] hrdata;
  logic        hready, hresp, pc_jump, pc_dummy, div_src, div_pin, xtal_lp, clk_slow, halted;
  logic [7:0]  pc_low, port_en, a, k, st, d;
  logic [3:0]  op;
  logic [11:0] ex;
  logic [19:0] corner [5] = '{20'h08080, 20'h10001, 20'h00f01, 20'h07f01, 20'h11001};
  int          error_cnt = 0;
  int          checks_done = 0;
  int          seed = 51;
  int          i;
  always #2.5 sys_clk = ~sys_clk;
  csi_core_sfr dut_u (
    .SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .WDT_TIMEOUT_I(wdt), .CLK_CFG_SLOW_I(cfg), .PC_JUMP_O(pc_jump), .PC_LOW_O(pc_low),
    .PC_DUMMY_O(pc_dummy), .PORT_OUT_EN_O(port_en), .DIV_SRC_O(div_src),
    .DIV_PIN_EN_O(div_pin), .SLOW_XTAL_LP_O(xtal_lp), .SYS_CLK_SLOW_O(clk_slow),
    .HALTED_O(halted)
  );
  //////////////////////////////
  task end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // ready is read before this edge's updates land, as the bus samples it
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      error_cnt++;
      end_sim;
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {21'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic wr(input logic [8:0] idx, input logic [31:0] v);
    logic [31:0] t;
    bus(1'b1, idx, v, t);
  endtask
  task automatic rd_chk(input logic [8:0] idx, input logic [31:0] e);
    logic [31:0] t;
    bus(1'b0, idx, 32'h0, t);
    chk(t, e);
  endtask
  task automatic cmd(input logic [3:0] o, input logic [7:0] v);
    wr(`CSI_IDX_CMD, {20'h0, o, v});
  endtask
  task pulse_wdt;
    wdt <= 1'b1;
    @(posedge sys_clk);
    wdt <= 1'b0;
  endtask
  // returns {ov, z, ac, c, result}; logic ops touch z only
  function automatic logic [11:0] alu(input logic [3:0] o, input logic [7:0] x, y,
                                      input logic [3:0] f);
    logic [7:0] b;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    logic [7:0] r;
    b = (o == `CSI_OP_SUB) ? ~y : y;
    s = x + b + (o == `CSI_OP_SUB);
    h = x[3:0] + b[3:0] + (o == `CSI_OP_SUB);
    l = x[6:0] + b[6:0] + (o == `CSI_OP_SUB);
    case (o)
      `CSI_OP_ADD, `CSI_OP_SUB: return {l[7] ^ s[8], s[7:0] == 8'h0, h[4], s[8], s[7:0]};
      `CSI_OP_AND: r = x & y;
      `CSI_OP_OR: r = x | y;
      `CSI_OP_RLC: return {f[3:1], x[7], x[6:0], f[0]};
      `CSI_OP_RRC: return {f[3:1], x[0], f[0], x[7:1]};
      default: r = x ^ y;
    endcase
    return {f[3], r == 8'h0, f[1:0], r};
  endfunction
  //////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk(port_en, 32'h0);
    rd_chk(`CSI_A_BP, 32'h0);
    rd_chk(`CSI_A_SYSTEM_CONTROL_FIRST, 32'h0);
    rd_chk(`CSI_A_STATUS, 32'h0);
    rd_chk(8'h38, 32'h0);
    chk(hresp, 32'h0);
    a = $random(seed);
    k = $random(seed);
    wr(`CSI_A_MP0, 8'h45);
    wr(`CSI_A_FIRST_INDIRECT_WINDOW, a);
    wr(`CSI_A_BP, 8'hff);
    rd_chk(`CSI_A_BP, 32'h1);
    wr(`CSI_A_MP1, 8'h45);
    wr(`CSI_A_SECOND_INDIRECT_WINDOW, k);
    rd_chk(8'h45, a);
    rd_chk(`CSI_A_FIRST_INDIRECT_WINDOW, a);
    rd_chk(`CSI_A_SECOND_INDIRECT_WINDOW, k);
    wr(`CSI_A_MP1, `CSI_A_MP0);
    rd_chk(`CSI_A_SECOND_INDIRECT_WINDOW, 32'h45);
    wr(`CSI_A_MP0, `CSI_A_SECOND_INDIRECT_WINDOW);
    wr(`CSI_A_FIRST_INDIRECT_WINDOW, 8'hff);
    rd_chk(`CSI_A_FIRST_INDIRECT_WINDOW, 32'h0);
    rd_chk(`CSI_A_SECOND_INDIRECT_WINDOW, 32'h2);
    wr(`CSI_A_BP, 8'h0);
    wr(`CSI_A_MP1, 8'h45);
    rd_chk(`CSI_A_SECOND_INDIRECT_WINDOW, a);
    for (i = 0; i < 40; i++) begin
      op = {$random(seed)} % 7;
      a = $random(seed);
      k = $random(seed);
      st = $random(seed);
      if (i < 5)
        {op, a, k} = corner[i];
      wr(`CSI_A_STATUS, st);
      cmd(`CSI_OP_MOVK, a);
      cmd(op, k);
      ex = alu(op, a, k, st[3:0]);
      rd_chk(`CSI_A_ACC, ex[7:0]);
      rd_chk(`CSI_A_STATUS, ex[11:8]);
    end
    wr(`CSI_A_STATUS, 8'h0);
    wr(`CSI_A_BP, 8'h1);
    cmd(`CSI_OP_HALT, 8'h0);
    // the halted pin trails the internal state by one register
    @(posedge sys_clk);
    chk(halted, 32'h1);
    wr(`CSI_A_STATUS, 8'h30);
    rd_chk(`CSI_A_STATUS, 32'h10);
    pulse_wdt;
    rd_chk(`CSI_A_STATUS, 32'h30);
    rd_chk(`CSI_A_BP, 32'h1);
    chk(halted, 32'h0);
    cmd(`CSI_OP_CLRWDT, 8'h0);
    rd_chk(`CSI_A_STATUS, 32'h0);
    pulse_wdt;
    rd_chk(`CSI_A_STATUS, 32'h20);
    rd_chk(`CSI_A_BP, 32'h0);
    cmd(`CSI_OP_HALT, 8'h0);
    rd_chk(`CSI_A_STATUS, 32'h10);
    wr(`CSI_A_BP, 8'h1);
    cmd(`CSI_OP_SOFTRST, 8'h0);
    rd_chk(`CSI_A_BP, 32'h0);
    chk(halted, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      cfg <= $random(seed);
      wr(`CSI_A_PCL, d);
      chk({pc_jump, pc_low}, {1'b1, d});
      @(posedge sys_clk);
      chk({pc_jump, pc_dummy}, 32'h1);
      wr(`CSI_A_PAC, d);
      @(posedge sys_clk);
      chk(port_en, {24'h000000, ~d});
      wr(`CSI_A_SYSTEM_CONTROL_FIRST, d);
      // let the config pin cross its synchroniser first
      repeat (3) @(posedge sys_clk);
      chk({div_src, div_pin, xtal_lp, clk_slow}, {d[6], d[2], d[1], d[0] & cfg});
      rd_chk(`CSI_A_SYSTEM_CONTROL_FIRST, d & 8'h47);
    end
    wr(`CSI_A_BP, 8'h1);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_chk(`CSI_A_BP, 32'h0);
    rd_chk(`CSI_A_STATUS, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
